// ===== bench/ccr_host_model.sv
`timescale 1ns/100ps
module ccr_host_model (
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic wd_refresh,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        wd_refresh = 1'b0;
    end

    // ----------------------------------------------------------------
    // host bus cycles
    // ----------------------------------------------------------------
    // released write data is inverted so a stale value cannot pass for a good one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask

    task automatic refresh();
        @(posedge core_clk);
        wd_refresh <= 1'b1;
        @(posedge core_clk);
        wd_refresh <= 1'b0;
    endtask
endmodule

// ===== bench/charger_config_registers_5_to_7_tb.sv
`timescale 1ns/100ps
module charger_config_registers_5_to_7_tb;
    localparam int CPS = 10;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, wd_refresh, reg_rvalid, reg_reset_cmd, detect_done, in_regulation;
    logic wd_expired, term_enable, short_deglitch, safety_timer_en, long_safety_timer;
    logic high_thermal_threshold, cold_fifth_current, force_input_detection;
    logic safety_tick_half, battery_switch_off, battery_switch_reset_enable;
    logic [1:0] input_overvoltage_threshold, boost_output_voltage;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, v;
    logic [13:0] battery_mv, charge_v_mv, input_limit_mv, warm_charge_mv;
    logic [15:0] tk [4] = '{16'h0000, 16'h00C8, 16'h00FA, 16'h012C};
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int wd_cnt = 0;
    int n;
    int lim;

    ccr_config_regs #(.CYCLES_PER_SEC(CPS)) i_dut (.core_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rvalid, .reg_reset_cmd, .wd_refresh, .detect_done,
        .in_regulation, .battery_mv, .charge_v_mv, .wd_expired, .term_enable, .short_deglitch,
        .safety_timer_en, .long_safety_timer, .high_thermal_threshold, .cold_fifth_current,
        .input_overvoltage_threshold, .boost_output_voltage, .input_limit_mv, .warm_charge_mv,
        .force_input_detection, .safety_tick_half, .battery_switch_off,
        .battery_switch_reset_enable);

    ccr_host_model i_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .wd_refresh,
        .reg_rdata, .reg_rvalid);

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    // the ceiling sits well above the longest watchdog wait
    always @(negedge core_clk)
    begin
        cyc++;
        if (wd_expired === 1'b1)
            wd_cnt++;
        if (cyc == 12000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cwait(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, rv);
        chk("rdata", 16'(rv), 16'(e));
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_host.wr(a, d);
        cwait(3);
    endtask

    function automatic logic [5:0] fl();
        return {term_enable, short_deglitch, safety_timer_en, long_safety_timer,
            high_thermal_threshold, cold_fifth_current};
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        reg_reset_cmd = 1'b0;
        detect_done = 1'b0;
        in_regulation = 1'b0;
        battery_mv = 14'h0FA0;
        charge_v_mv = 14'h1068;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rc(8'h05, 8'hBF);
        rc(8'h06, 8'hE6);
        rc(8'h07, 8'h4C);
        chk("flags", 16'(fl()), 16'h002F);
        chk("ovp_boost", 16'({input_overvoltage_threshold, boost_output_voltage}),
            16'h000E);
        chk("switch", 16'({force_input_detection, battery_switch_off,
            battery_switch_reset_enable}), 16'h0001);
        i_host.wr(8'h08, 8'h55);
        rc(8'h08, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            v = (i == 1) ? 8'h8F : 8'h40;
            w(8'h05, v);
            chk("flags", 16'(fl()),
                16'({v[7], v[6], v[3], v[2], v[1], v[0]}));
            rc(8'h05, v);
        end
        for (int k = 0; k < 4; k++)
        begin
            v = {k[1:0], k[1:0], 4'(k * 5)};
            w(8'h06, v);
            chk("ovp_boost", 16'({input_overvoltage_threshold, boost_output_voltage}),
                16'(v[7:4]));
            chk("limit", 16'(input_limit_mv), 16'h0F3C + 16'(k) * 16'h01F4);
        end
        w(8'h06, 8'h00);
        for (int t = 0; t < 4; t++)
        begin
            w(8'h07, 8'h4C | 8'(t));
            chk("limit", 16'(input_limit_mv), (t == 0) ? 16'h0F3C : 16'h0FA0 + tk[t]);
        end
        @(posedge core_clk);
        battery_mv <= 14'h0BB8;
        w(8'h07, 8'h4F);
        chk("limit", 16'(input_limit_mv), 16'h0F3C);
        w(8'h07, 8'h4C);
        chk("warm", 16'(warm_charge_mv), 16'h1004);
        w(8'h07, 8'h5C);
        chk("warm", 16'(warm_charge_mv), 16'h1068);
        @(posedge core_clk);
        charge_v_mv <= 14'h0FA0;
        w(8'h07, 8'h4C);
        chk("warm", 16'(warm_charge_mv), 16'h0FA0);
        w(8'h07, 8'hCC);
        chk("force", 16'(force_input_detection), 16'h0001);
        @(posedge core_clk);
        detect_done <= 1'b1;
        @(posedge core_clk);
        detect_done <= 1'b0;
        rc(8'h07, 8'h4C);
        w(8'h07, 8'h64);
        chk("off", 16'(battery_switch_off), 16'h0001);
        w(8'h07, 8'h4C);
        chk("off", 16'(battery_switch_off), 16'h0000);
        w(8'h07, 8'h6C);
        cwait(10 * CPS);
        chk("off", 16'(battery_switch_off), 16'h0000);
        cwait(3 * CPS);
        chk("off", 16'(battery_switch_off), 16'h0001);
        @(posedge core_clk);
        in_regulation <= 1'b1;
        for (int h = 0; h < 2; h++)
        begin
            w(8'h07, (h == 1) ? 8'h0C : 8'h4C);
            n = 0;
            repeat (20 * CPS)
            begin
                cwait(1);
                if (safety_tick_half === 1'b1)
                    n++;
            end
            chk("ticks", 16'(n), (h == 1) ? 16'h0014 : 16'h000A);
        end
        @(posedge core_clk);
        in_regulation <= 1'b0;
        w(8'h07, 8'h3B);
        chk("rst_en", 16'(battery_switch_reset_enable), 16'h0000);
        chk("wd_quiet", 16'(wd_cnt), 16'h0000);
        for (int k = 1; k < 4; k++)
        begin
            w(8'h05, {2'b10, k[1:0], 4'hF});
            if (k == 1)
            begin
                cwait(30 * CPS);
                i_host.refresh();
            end
            n = 0;
            lim = (40 << (k - 1)) * CPS;
            while (wd_expired !== 1'b1 && n < 2000)
            begin
                cwait(1);
                n++;
            end
            chk("wd_span", 16'(n >= lim - 13 && n <= lim + 3), 16'h0001);
        end
        cwait(3);
        rc(8'h05, 8'hBF);
        rc(8'h06, 8'h00);
        rc(8'h07, 8'h6F);
        @(posedge core_clk);
        reg_reset_cmd <= 1'b1;
        @(posedge core_clk);
        reg_reset_cmd <= 1'b0;
        rc(8'h06, 8'hE6);
        rc(8'h07, 8'h4C);
        give_verdict();
    end
endmodule

// ===== hdl/ccr_cfg_if.sv
`timescale 1ns/100ps
interface ccr_cfg_if;
    logic [7:0] timer_ctrl;
    logic [7:0] input_prot;
    logic [7:0] batsw_ctrl;
    modport regs (output timer_ctrl, output input_prot, output batsw_ctrl);
    modport user (input timer_ctrl, input input_prot, input batsw_ctrl);
endinterface

// ===== hdl/ccr_config_regs.sv
`timescale 1ns/100ps
module ccr_config_regs #(
    parameter int CYCLES_PER_SEC = ccr_pkg::CLK_HZ
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic reg_reset_cmd,
    input wire logic wd_refresh,
    input wire logic detect_done,
    input wire logic in_regulation,
    input wire logic [13:0] battery_mv,
    input wire logic [13:0] charge_v_mv,
    output logic wd_expired,
    output logic term_enable,
    output logic short_deglitch,
    output logic safety_timer_en,
    output logic long_safety_timer,
    output logic high_thermal_threshold,
    output logic cold_fifth_current,
    output logic [1:0] input_overvoltage_threshold,
    output logic [1:0] boost_output_voltage,
    output logic [13:0] input_limit_mv,
    output logic [13:0] warm_charge_mv,
    output logic force_input_detection,
    output logic safety_tick_half,
    output logic battery_switch_off,
    output logic battery_switch_reset_enable
);
    // -----------------------------------------------------------------
    // registers and write path
    // -----------------------------------------------------------------
    localparam int WD_MAX_S = 4 * ccr_pkg::WD_UNIT_S;
    ccr_cfg_if cfg ();
    logic [7:0] timer_ctrl_reg;
    logic [7:0] input_prot_reg;
    logic [7:0] batsw_ctrl_reg;
    logic [7:0] wd_sec_reg;
    logic sec_tick;
    logic half_phase_reg;
    logic [4:0] dly_sec_reg;
    logic [1:0] wd_sel;
    logic wd_fire;
    ccr_pkg::ccr_sw_state_t sw_state_reg;

    assign cfg.timer_ctrl = timer_ctrl_reg;
    assign cfg.input_prot = input_prot_reg;
    assign cfg.batsw_ctrl = batsw_ctrl_reg;
    assign wd_sel = timer_ctrl_reg[ccr_pkg::TC_WD_HI:ccr_pkg::TC_WD_LO];

    function automatic logic [7:0] wd_period(input logic [1:0] sel);
        wd_period = 8'(ccr_pkg::WD_UNIT_S) << (sel - 2'd1);
    endfunction

    function automatic logic is_write(input logic wr, input logic [7:0] a,
                                      input logic [7:0] want);
        is_write = wr && (a == want);
    endfunction

    assign wd_fire = (wd_sel != 2'b00) && sec_tick
                     && (wd_sec_reg + 8'h1 >= wd_period(wd_sel));

    ccr_sec_tick #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .tick(sec_tick)
    );

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            timer_ctrl_reg <= ccr_pkg::RST_TIMER_CTRL;
        else if (reg_reset_cmd || wd_expired)
            timer_ctrl_reg <= ccr_pkg::RST_TIMER_CTRL;
        else if (is_write(reg_wr, reg_addr, ccr_pkg::ADDR_TIMER_CTRL))
            timer_ctrl_reg <= reg_wdata;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            input_prot_reg <= ccr_pkg::RST_INPUT_PROT;
        else if (reg_reset_cmd)
            input_prot_reg <= ccr_pkg::RST_INPUT_PROT;
        else if (is_write(reg_wr, reg_addr, ccr_pkg::ADDR_INPUT_PROT))
            input_prot_reg <= reg_wdata;
    end

    // hardware clear of the detect bit wins over a host write of the same cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            batsw_ctrl_reg <= ccr_pkg::RST_BATSW_CTRL;
        else if (reg_reset_cmd)
            batsw_ctrl_reg <= ccr_pkg::RST_BATSW_CTRL;
        else if (wd_expired)
            batsw_ctrl_reg <= (batsw_ctrl_reg & ccr_pkg::BATSW_WD_KEEP)
                              | (ccr_pkg::RST_BATSW_CTRL & ~ccr_pkg::BATSW_WD_KEEP);
        else if (is_write(reg_wr, reg_addr, ccr_pkg::ADDR_BATSW_CTRL))
        begin
            batsw_ctrl_reg <= reg_wdata;
            if (detect_done)
                batsw_ctrl_reg[ccr_pkg::BS_FORCE_DET] <= 1'b0;
        end
        else if (detect_done)
            batsw_ctrl_reg[ccr_pkg::BS_FORCE_DET] <= 1'b0;
    end

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            case (reg_addr)
                ccr_pkg::ADDR_TIMER_CTRL: reg_rdata <= timer_ctrl_reg;
                ccr_pkg::ADDR_INPUT_PROT: reg_rdata <= input_prot_reg;
                ccr_pkg::ADDR_BATSW_CTRL: reg_rdata <= batsw_ctrl_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // host watchdog
    // -----------------------------------------------------------------
    // a refresh or a write restarts the count; period changes take effect at once
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wd_sec_reg <= 8'h00;
            wd_expired <= 1'b0;
        end
        else
        begin
            wd_expired <= wd_fire;
            if (wd_refresh || reg_wr || wd_sel == 2'b00 || wd_fire)
                wd_sec_reg <= 8'h00;
            else if (sec_tick)
                wd_sec_reg <= wd_sec_reg + 8'h1;
        end
    end

    // -----------------------------------------------------------------
    // battery switch off sequence
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sw_state_reg <= ccr_pkg::CCR_SW_ON;
            dly_sec_reg <= 5'h00;
        end
        else
        begin
            case (sw_state_reg)
                ccr_pkg::CCR_SW_ON:
                begin
                    dly_sec_reg <= 5'h00;
                    if (cfg.batsw_ctrl[ccr_pkg::BS_DISABLE])
                        sw_state_reg <= cfg.batsw_ctrl[ccr_pkg::BS_OFF_DLY]
                                        ? ccr_pkg::CCR_SW_WAIT : ccr_pkg::CCR_SW_OFF;
                end
                ccr_pkg::CCR_SW_WAIT:
                begin
                    if (!cfg.batsw_ctrl[ccr_pkg::BS_DISABLE])
                        sw_state_reg <= ccr_pkg::CCR_SW_ON;
                    else if (sec_tick)
                    begin
                        dly_sec_reg <= dly_sec_reg + 5'h01;
                        if (dly_sec_reg == 5'(ccr_pkg::SWITCH_DELAY_S - 1))
                            sw_state_reg <= ccr_pkg::CCR_SW_OFF;
                    end
                end
                ccr_pkg::CCR_SW_OFF:
                begin
                    if (!cfg.batsw_ctrl[ccr_pkg::BS_DISABLE])
                        sw_state_reg <= ccr_pkg::CCR_SW_ON;
                end
                default: sw_state_reg <= ccr_pkg::CCR_SW_ON;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // decoded settings toward the analog side
    // -----------------------------------------------------------------
    logic [13:0] lim_base;
    logic [13:0] lim_reg_mv;
    logic [13:0] track_ofs;
    logic [13:0] track_mv;
    logic [1:0] track_sel;

    // the offset selector has no register bit here; it is held at its default code
    assign lim_base = ccr_pkg::OFS_00_MV;
    assign lim_reg_mv = lim_base + 14'(cfg.input_prot[ccr_pkg::IP_LIM_HI:ccr_pkg::IP_LIM_LO])
                        * ccr_pkg::LIM_STEP_MV;
    assign track_sel = cfg.batsw_ctrl[ccr_pkg::BS_TRACK_HI:ccr_pkg::BS_TRACK_LO];
    always_comb
    begin
        case (track_sel)
            2'b01: track_ofs = ccr_pkg::TRACK_01_MV;
            2'b10: track_ofs = ccr_pkg::TRACK_10_MV;
            2'b11: track_ofs = ccr_pkg::TRACK_11_MV;
            default: track_ofs = 14'h0000;
        endcase
    end
    assign track_mv = battery_mv + track_ofs;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            half_phase_reg <= 1'b0;
        else if (sec_tick)
            half_phase_reg <= ~half_phase_reg;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            term_enable <= 1'b1;
            short_deglitch <= 1'b0;
            safety_timer_en <= 1'b1;
            long_safety_timer <= 1'b1;
            high_thermal_threshold <= 1'b1;
            cold_fifth_current <= 1'b1;
            input_overvoltage_threshold <= 2'b11;
            boost_output_voltage <= 2'b10;
            input_limit_mv <= 14'h0000;
            warm_charge_mv <= 14'h0000;
            force_input_detection <= 1'b0;
            safety_tick_half <= 1'b0;
            battery_switch_off <= 1'b0;
            battery_switch_reset_enable <= 1'b1;
        end
        else
        begin
            term_enable <= cfg.timer_ctrl[ccr_pkg::TC_TERM_EN];
            short_deglitch <= cfg.timer_ctrl[ccr_pkg::TC_DEGLITCH];
            safety_timer_en <= cfg.timer_ctrl[ccr_pkg::TC_SAFE_EN];
            long_safety_timer <= cfg.timer_ctrl[ccr_pkg::TC_SAFE_DUR];
            high_thermal_threshold <= cfg.timer_ctrl[ccr_pkg::TC_THERM];
            cold_fifth_current <= cfg.timer_ctrl[ccr_pkg::TC_COLD];
            input_overvoltage_threshold <=
                cfg.input_prot[ccr_pkg::IP_OVP_HI:ccr_pkg::IP_OVP_LO];
            boost_output_voltage <=
                cfg.input_prot[ccr_pkg::IP_BOOST_HI:ccr_pkg::IP_BOOST_LO];
            if (track_sel != 2'b00 && track_mv > lim_reg_mv)
                input_limit_mv <= track_mv;
            else
                input_limit_mv <= lim_reg_mv;
            if (!cfg.batsw_ctrl[ccr_pkg::BS_WARM_V] && charge_v_mv > ccr_pkg::WARM_CAP_MV)
                warm_charge_mv <= ccr_pkg::WARM_CAP_MV;
            else
                warm_charge_mv <= charge_v_mv;
            force_input_detection <= cfg.batsw_ctrl[ccr_pkg::BS_FORCE_DET];
            // one-second pulse, or every second one while slowed
            safety_tick_half <= sec_tick && cfg.timer_ctrl[ccr_pkg::TC_SAFE_EN]
                && (!(cfg.batsw_ctrl[ccr_pkg::BS_HALF_RATE] && in_regulation)
                    || half_phase_reg);
            battery_switch_off <= (sw_state_reg == ccr_pkg::CCR_SW_OFF);
            battery_switch_reset_enable <= cfg.batsw_ctrl[ccr_pkg::BS_RST_EN];
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    reg_reset_val_a: assert property (@(posedge core_clk) disable iff (rst)
        reg_reset_cmd |=> input_prot_reg == ccr_pkg::RST_INPUT_PROT)
        else $error("register reset missed input register");
    wd_restore_a: assert property (@(posedge core_clk) disable iff (rst)
        wd_expired && !reg_wr |=> timer_ctrl_reg == ccr_pkg::RST_TIMER_CTRL)
        else $error("watchdog did not restore timer register");
    wd_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        wd_expired && !reg_reset_cmd |=>
        (batsw_ctrl_reg & ccr_pkg::BATSW_WD_KEEP)
        == ($past(batsw_ctrl_reg) & ccr_pkg::BATSW_WD_KEEP))
        else $error("watchdog touched register-reset-only bits");
    detect_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        detect_done && !reg_reset_cmd |=> !batsw_ctrl_reg[ccr_pkg::BS_FORCE_DET])
        else $error("detect bit not cleared");
    term_follow_a: assert property (@(posedge core_clk) disable iff (rst)
        ##1 term_enable == $past(timer_ctrl_reg[ccr_pkg::TC_TERM_EN]))
        else $error("termination enable mismatch");
    sw_immediate_a: assert property (@(posedge core_clk) disable iff (rst)
        sw_state_reg == ccr_pkg::CCR_SW_ON && batsw_ctrl_reg[ccr_pkg::BS_DISABLE]
        && !batsw_ctrl_reg[ccr_pkg::BS_OFF_DLY] |=> ##1 battery_switch_off)
        else $error("immediate switch off late");
    sw_release_a: assert property (@(posedge core_clk) disable iff (rst)
        !batsw_ctrl_reg[ccr_pkg::BS_DISABLE] |=> ##1 !battery_switch_off)
        else $error("switch stayed off after enable");
    limit_max_a: assert property (@(posedge core_clk) disable iff (rst)
        // the limit output reads zero until the first edge after reset, so skip that edge
        !$past(rst) |-> input_limit_mv >= $past(lim_reg_mv))
        else $error("input limit below register threshold");
    wd_off_a: assert property (@(posedge core_clk) disable iff (rst)
        wd_sel == 2'b00 |=> !wd_expired)
        else $error("disabled watchdog expired");
    half_rate_a: assert property (@(posedge core_clk) disable iff (rst)
        safety_tick_half |-> $past(sec_tick))
        else $error("safety tick without second pulse");
endmodule

// ===== hdl/ccr_pkg.sv
package ccr_pkg;
    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h05;
    localparam logic [7:0] ADDR_INPUT_PROT = 8'h06;
    localparam logic [7:0] ADDR_BATSW_CTRL = 8'h07;
    localparam logic [7:0] RST_TIMER_CTRL = 8'hBF;
    localparam logic [7:0] RST_INPUT_PROT = 8'hE6;
    localparam logic [7:0] RST_BATSW_CTRL = 8'h4C;
    // bits of the switch register that a watchdog expiry leaves alone
    localparam logic [7:0] BATSW_WD_KEEP = 8'h2B;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int TC_TERM_EN = 7;
    localparam int TC_DEGLITCH = 6;
    localparam int TC_WD_HI = 5;
    localparam int TC_WD_LO = 4;
    localparam int TC_SAFE_EN = 3;
    localparam int TC_SAFE_DUR = 2;
    localparam int TC_THERM = 1;
    localparam int TC_COLD = 0;
    localparam int IP_OVP_HI = 7;
    localparam int IP_OVP_LO = 6;
    localparam int IP_BOOST_HI = 5;
    localparam int IP_BOOST_LO = 4;
    localparam int IP_LIM_HI = 3;
    localparam int IP_LIM_LO = 0;
    localparam int BS_FORCE_DET = 7;
    localparam int BS_HALF_RATE = 6;
    localparam int BS_DISABLE = 5;
    localparam int BS_WARM_V = 4;
    localparam int BS_OFF_DLY = 3;
    localparam int BS_RST_EN = 2;
    localparam int BS_TRACK_HI = 1;
    localparam int BS_TRACK_LO = 0;

    // -----------------------------------------------------------------
    // timing and voltage figures
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int WD_UNIT_S = 40;
    localparam int SWITCH_DELAY_S = 12;
    localparam int DEGLITCH_LONG_MS = 230;
    localparam int DEGLITCH_SHORT_MS = 16;
    localparam int SAFE_SHORT_H = 7;
    localparam int SAFE_LONG_H = 16;
    localparam int THERM_LOW_C = 80;
    localparam int THERM_HIGH_C = 120;
    localparam int COLD_HALF_PCT = 50;
    localparam int COLD_FIFTH_PCT = 20;
    localparam logic [13:0] LIM_STEP_MV = 14'h0064;
    localparam logic [13:0] OFS_00_MV = 14'h0F3C;   // 3900
    localparam logic [13:0] OFS_01_MV = 14'h170C;   // 5900
    localparam logic [13:0] OFS_10_MV = 14'h1D4C;   // 7500
    localparam logic [13:0] OFS_11_MV = 14'h2904;   // 10500
    localparam logic [13:0] TRACK_01_MV = 14'h00C8;
    localparam logic [13:0] TRACK_10_MV = 14'h00FA;
    localparam logic [13:0] TRACK_11_MV = 14'h012C;
    localparam logic [13:0] WARM_CAP_MV = 14'h1004;  // 4100

    typedef enum logic [1:0]
    {
        CCR_SW_ON = 2'b00,
        CCR_SW_WAIT = 2'b01,
        CCR_SW_OFF = 2'b11
    } ccr_sw_state_t;
endpackage

// ===== hdl/ccr_sec_tick.sv
`timescale 1ns/100ps
module ccr_sec_tick #(
    parameter int CYCLES_PER_SEC = ccr_pkg::CLK_HZ
)(
    input wire logic core_clk,
    input wire logic rst,
    output logic tick
);
    // -----------------------------------------------------------------
    // one-second enable pulse
    // -----------------------------------------------------------------
    logic [31:0] cnt_reg;

    initial
    begin
        if (CYCLES_PER_SEC < 2)
            $error("CYCLES_PER_SEC must be at least 2");
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end
        else if (cnt_reg == 32'(CYCLES_PER_SEC - 1))
        begin
            cnt_reg <= 32'h0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule
